// File: hdl/acg_pkg.sv
/*
  acg_pkg: register map, field positions, reset values and oscillator codes
  for the auxiliary and reference clock generator.
  Assumes a single 50 MHz system clock and a plain strobe register port.
*/
`default_nettype none
package acg_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  localparam int          PER_W           = 16;
  localparam int          DIV_W           = 8;

  localparam logic [3:0]  OSC_CTRL_ADDR   = 4'h0;
  localparam logic [3:0]  AUX_CTRL_ADDR   = 4'h1;
  localparam logic [3:0]  REF_CTRL_ADDR   = 4'h2;

  localparam int          OSC_CUR_LSB     = 12;
  localparam int          OSC_NEW_LSB     = 8;
  localparam int          OSC_LOCK_BIT    = 7;
  localparam int          OSC_FAIL_BIT    = 3;
  localparam int          OSC_SWREQ_BIT   = 0;

  localparam int          AUX_EN_BIT      = 15;
  localparam int          AUX_LOCKED_BIT  = 14;
  localparam int          AUX_SRC_BIT     = 0;

  localparam int          REF_EN_BIT      = 15;
  localparam int          REF_SRC_BIT     = 14;
  localparam int          REF_DIV_LSB     = 0;

  localparam logic [2:0]  SEL_FRC         = 3'h0;
  localparam logic [2:0]  SEL_FRC_PLL     = 3'h1;
  localparam logic [2:0]  SEL_PRI         = 3'h2;
  localparam logic [2:0]  SEL_PRI_PLL     = 3'h3;
  localparam logic [2:0]  SEL_RESERVED    = 3'h4;
  localparam logic [2:0]  SEL_LOW_POWER_RC_OSC        = 3'h5;
  localparam logic [2:0]  SEL_FRC_DIV16   = 3'h6;
  localparam logic [2:0]  SEL_FRC_DIVN    = 3'h7;
  localparam logic [2:0]  OSC_SEL_RESET   = 3'h7;

  localparam logic [PER_W:0] AUX_MULT     = 17'h00010;
  localparam logic [PER_W-1:0] PER_MIN    = 16'h0010;
  localparam logic [DIV_W-1:0] REF_DIV_RESET = 8'h00;

  typedef enum logic [1:0] {
    ACG_UNLOCKED = 2'b01,
    ACG_LOCKED   = 2'b10
  } acg_pll_st_t;
endpackage
`default_nettype wire

// File: hdl/acg_ref_div.sv
/*
  acg_ref_div: programmable divider for the reference clock pin.
  Assumes source events are one-cycle pulses in the clk_sys domain.
*/
`timescale 1ns/10ps
`default_nettype none
module acg_ref_div (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic                      enable,
  input  wire logic                      src_crystal,
  input  wire logic                      crystal_rise,
  input  wire logic [acg_pkg::DIV_W-1:0] div_ratio,
  output var  logic                      ref_out
);
  logic [acg_pkg::DIV_W-1:0] cnt;
  logic [acg_pkg::DIV_W-1:0] next_cnt;
  logic                      next_ref_out;
  logic                      src_event;

  // the system clock source counts every cycle, so the pin shows clk_sys / (2*(ratio+1))
  assign src_event = src_crystal ? crystal_rise : 1'b1;

  always_comb begin
    next_cnt     = cnt;
    next_ref_out = ref_out;
    if (!enable) begin
      next_cnt     = '0;
      next_ref_out = 1'b0;
    end else if (src_event) begin
      if (cnt >= div_ratio) begin
        next_cnt     = '0;
        next_ref_out = ~ref_out;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt     <= '0;
      ref_out <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      ref_out <= next_ref_out;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_ref_wrap;
    enable && src_event && (cnt >= div_ratio);
  endsequence

  sequence s_ref_hold;
    enable && !(src_event && (cnt >= div_ratio));
  endsequence

  AST_REF_DIV: assert property (s_ref_wrap |=> (ref_out != $past(ref_out)) && (cnt == 8'h00))
    else $error("reference output did not toggle at the end of its divide count");
  AST_REF_HOLD: assert property (s_ref_hold ##1 enable |-> $stable(ref_out))
    else $error("reference output toggled before its divide count ran out");
endmodule // acg_ref_div
`default_nettype wire

// File: hdl/acg_clkgen.sv
/*
  acg_clkgen: auxiliary clock generator with fixed x16 digital PLL model,
  oscillator control register and reference clock pin output.
  Assumes oscillator inputs are already synchronous to clk_sys and that the
  register master issues single-cycle read or write strobes.
*/
`timescale 1ns/10ps
`default_nettype none
module acg_clkgen (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic [acg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [acg_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output var  logic [acg_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       crystal_in,
  input  wire logic                       frc_in,
  output var  logic                       aux_clk_tick,
  output var  logic                       aux_locked,
  output var  logic                       refclk_out,
  output var  logic                       refclk_oe,
  output var  logic [2:0]                 current_osc_select
);
  // register state
  logic [2:0]                    new_osc_select;
  logic                          clock_source_lock;
  logic                          osc_switch_request;
  logic                          aux_en;
  logic                          aux_src_frc;
  logic                          ref_en;
  logic                          ref_src_crystal;
  logic [acg_pkg::DIV_W-1:0]     ref_div;
  logic [2:0]                    next_new_osc_select;
  logic [2:0]                    next_current_osc_select;
  logic                          next_clock_source_lock;
  logic                          next_osc_switch_request;
  logic                          next_aux_en;
  logic                          next_aux_src_frc;
  logic                          next_ref_en;
  logic                          next_ref_src_crystal;
  logic [acg_pkg::DIV_W-1:0]     next_ref_div;
  logic [acg_pkg::DATA_W-1:0]    next_reg_rdata;
  logic                          next_refclk_oe;

  // aux pll state
  logic                          crystal_q;
  logic                          frc_q;
  logic [acg_pkg::PER_W-1:0]     per_cnt;
  logic [acg_pkg::PER_W-1:0]     period;
  logic [acg_pkg::PER_W:0]       acc;
  acg_pkg::acg_pll_st_t          pll_st;
  logic [acg_pkg::PER_W-1:0]     next_per_cnt;
  logic [acg_pkg::PER_W-1:0]     next_period;
  logic [acg_pkg::PER_W:0]       next_acc;
  acg_pkg::acg_pll_st_t          next_pll_st;
  logic                          next_aux_clk_tick;
  logic                          next_aux_locked;

  logic                          crystal_rise;
  logic                          frc_rise;
  logic                          sel_rise;
  logic                          src_change;
  logic [acg_pkg::PER_W-1:0]     cnt_inc;
  logic [acg_pkg::PER_W:0]       acc_sum;
  logic                          wr_osc;
  logic                          wr_aux;
  logic                          wr_ref;

  function automatic logic hit(input logic [acg_pkg::ADDR_W-1:0] a, input logic [acg_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  assign wr_osc       = reg_wr && hit(reg_addr, acg_pkg::OSC_CTRL_ADDR);
  assign wr_aux       = reg_wr && hit(reg_addr, acg_pkg::AUX_CTRL_ADDR);
  assign wr_ref       = reg_wr && hit(reg_addr, acg_pkg::REF_CTRL_ADDR);
  assign crystal_rise = crystal_in && !crystal_q;
  assign frc_rise     = frc_in && !frc_q;
  assign sel_rise     = aux_src_frc ? frc_rise : crystal_rise;
  assign src_change   = wr_aux && (reg_wdata[acg_pkg::AUX_SRC_BIT] != aux_src_frc);
  // saturate so a stopped oscillator cannot wrap back into a false period
  assign cnt_inc      = (&per_cnt) ? per_cnt : per_cnt + 16'h0001;
  assign acc_sum      = acc + acg_pkg::AUX_MULT;

  // register file
  always_comb begin
    next_new_osc_select     = new_osc_select;
    next_current_osc_select = current_osc_select;
    next_clock_source_lock  = clock_source_lock;
    next_osc_switch_request = osc_switch_request;
    next_aux_en             = aux_en;
    next_aux_src_frc        = aux_src_frc;
    next_ref_en             = ref_en;
    next_ref_src_crystal    = ref_src_crystal;
    next_ref_div            = ref_div;
    next_reg_rdata          = '0;
    // a pending request completes one cycle after it was raised; reserved code is refused
    if (osc_switch_request) begin
      next_osc_switch_request = 1'b0;
      if (new_osc_select != acg_pkg::SEL_RESERVED) begin
        next_current_osc_select = new_osc_select;
      end
    end
    if (wr_osc && !clock_source_lock) begin
      next_new_osc_select = reg_wdata[acg_pkg::OSC_NEW_LSB +: 3];
      if (reg_wdata[acg_pkg::OSC_SWREQ_BIT]) begin
        next_osc_switch_request = 1'b1;
      end
    end
    // lock is sticky until reset so a runaway write cannot move the clock
    if (wr_osc && reg_wdata[acg_pkg::OSC_LOCK_BIT]) begin
      next_clock_source_lock = 1'b1;
    end
    if (wr_aux) begin
      next_aux_en      = reg_wdata[acg_pkg::AUX_EN_BIT];
      next_aux_src_frc = reg_wdata[acg_pkg::AUX_SRC_BIT];
    end
    if (wr_ref) begin
      next_ref_en          = reg_wdata[acg_pkg::REF_EN_BIT];
      next_ref_src_crystal = reg_wdata[acg_pkg::REF_SRC_BIT];
      next_ref_div         = reg_wdata[acg_pkg::REF_DIV_LSB +: acg_pkg::DIV_W];
    end
    if (reg_rd) begin
      case (reg_addr)
        acg_pkg::OSC_CTRL_ADDR: begin
          next_reg_rdata[acg_pkg::OSC_CUR_LSB +: 3] = current_osc_select;
          next_reg_rdata[acg_pkg::OSC_NEW_LSB +: 3] = new_osc_select;
          next_reg_rdata[acg_pkg::OSC_LOCK_BIT]     = clock_source_lock;
          next_reg_rdata[acg_pkg::OSC_FAIL_BIT]     = 1'b0;
          next_reg_rdata[acg_pkg::OSC_SWREQ_BIT]    = osc_switch_request;
        end
        acg_pkg::AUX_CTRL_ADDR: begin
          next_reg_rdata[acg_pkg::AUX_EN_BIT]     = aux_en;
          next_reg_rdata[acg_pkg::AUX_LOCKED_BIT] = aux_locked;
          next_reg_rdata[acg_pkg::AUX_SRC_BIT]    = aux_src_frc;
        end
        acg_pkg::REF_CTRL_ADDR: begin
          next_reg_rdata[acg_pkg::REF_EN_BIT]                     = ref_en;
          next_reg_rdata[acg_pkg::REF_SRC_BIT]                    = ref_src_crystal;
          next_reg_rdata[acg_pkg::REF_DIV_LSB +: acg_pkg::DIV_W] = ref_div;
        end
        default: begin
          next_reg_rdata = '0;
        end
      endcase
    end
    next_refclk_oe = next_ref_en;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      new_osc_select     <= acg_pkg::OSC_SEL_RESET;
      current_osc_select <= acg_pkg::OSC_SEL_RESET;
      clock_source_lock  <= 1'b0;
      osc_switch_request <= 1'b0;
      aux_en             <= 1'b0;
      aux_src_frc        <= 1'b0;
      ref_en             <= 1'b0;
      ref_src_crystal    <= 1'b0;
      ref_div            <= acg_pkg::REF_DIV_RESET;
      reg_rdata          <= '0;
      refclk_oe          <= 1'b0;
    end else begin
      new_osc_select     <= next_new_osc_select;
      current_osc_select <= next_current_osc_select;
      clock_source_lock  <= next_clock_source_lock;
      osc_switch_request <= next_osc_switch_request;
      aux_en             <= next_aux_en;
      aux_src_frc        <= next_aux_src_frc;
      ref_en             <= next_ref_en;
      ref_src_crystal    <= next_ref_src_crystal;
      ref_div            <= next_ref_div;
      reg_rdata          <= next_reg_rdata;
      refclk_oe          <= next_refclk_oe;
    end
  end

  // aux pll: measures the input period in clk_sys cycles and emits sixteen ticks per period;
  // limitation: the tick rate cannot exceed clk_sys, so inputs faster than clk_sys/16 never lock
  always_comb begin
    next_per_cnt      = sel_rise ? '0 : cnt_inc;
    next_period       = sel_rise ? cnt_inc : period;
    next_acc          = '0;
    next_pll_st       = pll_st;
    next_aux_clk_tick = 1'b0;
    case (pll_st)
      acg_pkg::ACG_UNLOCKED: begin
        if (aux_en && !src_change && sel_rise && (cnt_inc == period) && (period >= acg_pkg::PER_MIN)) begin
          next_pll_st = acg_pkg::ACG_LOCKED;
        end
      end
      acg_pkg::ACG_LOCKED: begin
        // driven only by the input period, never by the system clock rate
        if (acc_sum >= {1'b0, period}) begin
          next_aux_clk_tick = 1'b1;
          next_acc          = acc_sum - {1'b0, period};
        end else begin
          next_acc = acc_sum;
        end
        if (!aux_en || src_change || (sel_rise && (cnt_inc != period)) || (&per_cnt)) begin
          next_pll_st       = acg_pkg::ACG_UNLOCKED;
          next_acc          = '0;
        end
      end
      default: begin
        next_pll_st = acg_pkg::ACG_UNLOCKED;
      end
    endcase
    if (src_change) begin
      next_per_cnt = '0;
      next_period  = '0;
    end
    next_aux_locked = (next_pll_st == acg_pkg::ACG_LOCKED);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      crystal_q    <= 1'b0;
      frc_q        <= 1'b0;
      per_cnt      <= '0;
      period       <= '0;
      acc          <= '0;
      pll_st       <= acg_pkg::ACG_UNLOCKED;
      aux_clk_tick <= 1'b0;
      aux_locked   <= 1'b0;
    end else begin
      crystal_q    <= crystal_in;
      frc_q        <= frc_in;
      per_cnt      <= next_per_cnt;
      period       <= next_period;
      acc          <= next_acc;
      pll_st       <= next_pll_st;
      aux_clk_tick <= next_aux_clk_tick;
      aux_locked   <= next_aux_locked;
    end
  end

  acg_ref_div u_ref_div (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .enable       (ref_en),
    .src_crystal  (ref_src_crystal),
    .crystal_rise (crystal_rise),
    .div_ratio    (ref_div),
    .ref_out      (refclk_out)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_switch;
    osc_switch_request && (new_osc_select != acg_pkg::SEL_RESERVED);
  endsequence

  AST_AUX_X16: assert property ((pll_st == acg_pkg::ACG_LOCKED) && aux_en && !src_change
    && (acc_sum >= {1'b0, period}) |=> aux_clk_tick && (acc < {1'b0, $past(period)}))
    else $error("aux tick missing when the x16 accumulator passed the period");
  AST_AUX_SRC: assert property ($rose(aux_locked) |-> $past(sel_rise) && $past(aux_en))
    else $error("aux pll locked without an edge of its selected input");
  AST_AUX_INDEP: assert property (aux_clk_tick |-> $past(pll_st == acg_pkg::ACG_LOCKED))
    else $error("aux tick produced while the pll was not locked");
  AST_REF_OFF: assert property (!ref_en ##1 !ref_en |-> !refclk_out && !refclk_oe)
    else $error("reference pin active while disabled");
  AST_REF_SRC: assert property (ref_en && ref_src_crystal && !crystal_rise |=> $stable(refclk_out))
    else $error("crystal sourced reference toggled without a crystal edge");
  // a legal back-to-back write may raise the next request in the cycle the previous one completes
  AST_OSC_CODE: assert property (s_switch |=> (current_osc_select == $past(new_osc_select))
    && (!osc_switch_request || $past(wr_osc && !clock_source_lock && reg_wdata[acg_pkg::OSC_SWREQ_BIT])))
    else $error("oscillator switch did not take the new selection");
  AST_CUR_RO: assert property (reg_wr && !osc_switch_request |=> $stable(current_osc_select))
    else $error("current oscillator field changed by a plain write");
  AST_RD_ZERO: assert property (reg_rd && (reg_addr > acg_pkg::REF_CTRL_ADDR) |=> reg_rdata == 16'h0000)
    else $error("unmapped address did not read zero");
endmodule // acg_clkgen
`default_nettype wire

// File: sim/acg_aux_sink.sv
/*
  acg_aux_sink: behavioural stand-in for the PWM and ADC side that runs from the aux ticks.
  Assumes ticks are one-cycle pulses in the clk_sys domain and a bench-driven counter clear.
*/
`timescale 1ns/10ps
`default_nettype none
module acg_aux_sink (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        aux_clk_tick,
  input  wire logic        aux_locked,
  input  wire logic        count_clr,
  output var  logic [15:0] tick_count
);
  logic [15:0] next_tick_count;

  // a tick only times the consumer while the pll reports lock
  always_comb begin
    next_tick_count = tick_count;
    if (count_clr) begin
      next_tick_count = 16'h0000;
    end else if (aux_clk_tick && aux_locked) begin
      next_tick_count = tick_count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_count <= 16'h0000;
    end else begin
      tick_count <= next_tick_count;
    end
  end
endmodule // acg_aux_sink
`default_nettype wire

// File: sim/aux_and_reference_clock_gen_tb_top.sv
/*
  aux_and_reference_clock_gen_tb_top: self-checking bench for acg_clkgen with the aux sink model.
  Assumes a 50 MHz clk_sys and oscillator levels made synchronous to clk_sys by this bench.
*/
`timescale 1ns/10ps
`default_nettype none
module aux_and_reference_clock_gen_tb_top;
  typedef struct packed { logic [2:0] code; logic [2:0] exp; } acg_row_t;
  logic        clk_sys    = 1'b0;
  logic        resetn     = 1'b0;
  logic [3:0]  reg_addr   = 4'h0;
  logic [15:0] reg_wdata  = 16'h0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        crystal_in = 1'b0;
  logic        frc_in     = 1'b0;
  logic        count_clr  = 1'b0;
  logic [15:0] reg_rdata, tick_count, d;
  logic        aux_clk_tick, aux_locked, refclk_out, refclk_oe;
  logic [2:0]  current_osc_select;
  int          n_fail = 0, checks_done = 0, cyc = 0, n = 0, xcnt = 0, fcnt = 0;
  // slow stand-ins for the 120 MHz setting; crystal, not the primary pll, feeds aux input
  int          xhalf = 16, fhalf = 32;
  // reserved code 100 is refused, so the previous selection stays active
  acg_row_t    rows [8] = '{'{3'h0, 3'h0}, '{3'h1, 3'h1}, '{3'h2, 3'h2}, '{3'h3, 3'h3},
                            '{3'h4, 3'h3}, '{3'h5, 3'h5}, '{3'h6, 3'h6}, '{3'h7, 3'h7}};

  acg_clkgen uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crystal_in(crystal_in), .frc_in(frc_in),
    .aux_clk_tick(aux_clk_tick), .aux_locked(aux_locked), .refclk_out(refclk_out),
    .refclk_oe(refclk_oe), .current_osc_select(current_osc_select));
  acg_aux_sink u_sink (.clk_sys(clk_sys), .resetn(resetn), .aux_clk_tick(aux_clk_tick),
    .aux_locked(aux_locked), .count_clr(count_clr), .tick_count(tick_count));

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc  <= cyc + 1;
    xcnt <= (xcnt == xhalf - 1) ? 0 : xcnt + 1;
    fcnt <= (fcnt == fhalf - 1) ? 0 : fcnt + 1;
    if (xcnt == xhalf - 1) begin
      crystal_in <= ~crystal_in;
    end
    if (fcnt == fhalf - 1) begin
      frc_in <= ~frc_in;
    end
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic wait_lock(input logic lvl);
    for (int i = 0; i < 400 && aux_locked !== lvl; i++) begin
      step(1);
    end
  endtask

  // cycles from now until the reference pin next changes level
  task automatic gap(output int g);
    logic v;
    v = refclk_out;
    g = 0;
    while (refclk_out === v && g < 200) begin
      step(1);
      g = g + 1;
    end
  endtask

  task automatic ticks(input int w, input logic [15:0] exp);
    count_clr <= 1'b1;
    step(1);
    count_clr <= 1'b0;
    step(w);
    chk("aux ticks", tick_count, exp);
  endtask

  initial begin
    step(8);
    chk("reset select", {13'h0000, current_osc_select}, 16'h0007);
    chk("reset locked", {15'h0000, aux_locked}, 16'h0000);
    chk("reset ref oe", {15'h0000, refclk_oe}, 16'h0000);
    chk("reset rdata", reg_rdata, 16'h0000);
    resetn <= 1'b1;
    step(1);
    foreach (rows[i]) begin
      wr(4'h0, {5'h00, rows[i].code, 8'h01});
      step(2);
      chk("current select", {13'h0000, current_osc_select}, {13'h0000, rows[i].exp});
      rd(4'h0, d);
      chk("osc ctrl", d, {1'b0, rows[i].exp, 1'b0, rows[i].code, 8'h00});
    end
    // current field read-only: written as 3 while 7 is active; fail flag and unused bits stay zero
    wr(4'h0, 16'h3a76);
    rd(4'h0, d);
    chk("osc ctrl ro", d, 16'h7200);
    rd(4'h3, d);
    chk("unmapped", d, 16'h0000);
    wr(4'h1, 16'h8000);
    wait_lock(1'b1);
    rd(4'h1, d);
    chk("aux ctrl crystal", d, 16'hc000);
    ticks(64, 16'h0020);
    wr(4'h1, 16'h8001);
    wait_lock(1'b0);
    wait_lock(1'b1);
    rd(4'h1, d);
    chk("aux ctrl frc", d, 16'hc001);
    ticks(128, 16'h0020);
    for (int k = 0; k < 2; k++) begin
      wr(4'h2, {8'h80, 8'(k * 3)});
      repeat (3) gap(n);
      chk("ref sys gap", n[15:0], 16'(k * 3 + 1));
      chk("ref oe", {15'h0000, refclk_oe}, 16'h0001);
    end
    wr(4'h2, 16'hc001);
    repeat (3) gap(n);
    chk("ref crystal gap", n[15:0], 16'(2 * 2 * xhalf));
    wr(4'h2, 16'h0000);
    step(2);
    chk("ref off oe", {15'h0000, refclk_oe}, 16'h0000);
    chk("ref off pin", {15'h0000, refclk_out}, 16'h0000);
    // lock takes new select 0, then a switch request to 5 is ignored
    wr(4'h0, 16'h0080);
    wr(4'h0, 16'h0501);
    step(2);
    chk("locked select", {13'h0000, current_osc_select}, 16'h0007);
    rd(4'h0, d);
    chk("osc ctrl locked", d, 16'h7080);
    step(1);
    chk("rdata clears", reg_rdata, 16'h0000);
    end_sim();
  end
endmodule // aux_and_reference_clock_gen_tb_top
`default_nettype wire
